// File: hdl/arc_conv_regs.sv
//------------------------------------------------------------------------------
// Purpose : result and control/status registers of a two-module converter
// Assumes : the sequencer pulses CONV_RET.done once per finished conversion
//           of the channel shown on CONV_CHAN while CONV_REQ is high
// Notes   : bus reads answer one cycle later on BUS_RDATA and hold there
//------------------------------------------------------------------------------
// Overview of operation
// - eight read-only 16-bit results, input n lands in result n
// - 10-bit value in bits 15:6, low six bits read zero
// - upper byte read directly; that read latches lower byte for later
// - all results read zero after reset
// - single mode sets end flag, bit 7, when the channel finishes
// - scan mode sets end flag only after all selected channels finish
// - end flag cleared by writing zero after reading one; one ignored
// - transfer-controller result read with mode bit zero clears end flag
// - bit 6 enables the end interrupt, zero masks it
// - bit 4 picks mode: zero single, one scan
// - bits 5 and 2 read zero, bit 3 reads one
// - single mode: channel field picks one of the module's four inputs
// - scan mode: code n scans first n+1 inputs ascending
// - start bit one starts, zero stops; single mode clears it when done
// - scan repeats until start cleared by software, reset or standby
`timescale 1ns/1ps
module arc_conv_regs
  import arc_pkg::*;
(
  input  wire logic                     MCLK,
  input  wire logic                     NRST,
  input  wire logic [4:0]               BUS_AD,
  input  wire logic                     BUS_RD,
  input  wire logic                     BUS_WR,
  input  wire logic [7:0]               BUS_WDATA,
  input  wire logic                     BUS_XFER,
  input  wire logic                     XFER_MODE_BIT,
  input  wire logic                     STANDBY,
  input  wire arc_conv_s [NUM_MOD-1:0]  CONV_RET,
  output logic      [7:0]               BUS_RDATA,
  output logic      [NUM_MOD-1:0]       CONV_REQ,
  output logic      [NUM_MOD-1:0][2:0]  CONV_CHAN,
  output logic      [NUM_MOD-1:0]       CONV_END_IRQ
);

  localparam logic [NUM_MOD-1:0][4:0] OFS_CSR   = {OFS_CSR_M1, OFS_CSR_M0};
  localparam logic [NUM_MOD-1:0][4:0] OFS_START =
    {OFS_START_M1, OFS_START_M0};

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic       res_rd;
  logic       res_rd_hi;
  logic [2:0] res_idx;

  // results occupy 0x00..0x0f, so bit 4 low marks a result byte
  assign res_rd    = BUS_RD && (BUS_AD[4] == OFS_RESULT_BASE[4]);
  assign res_rd_hi = res_rd && !BUS_AD[0];
  assign res_idx   = BUS_AD[3:1];

  // ----------------------------------------------------------------------
  // per-module control, status and sequencing
  // ----------------------------------------------------------------------
  logic      [NUM_MOD-1:0]            end_flag_r;
  logic      [NUM_MOD-1:0]            irq_en_r;
  arc_mode_e                          mode_r   [NUM_MOD];
  logic      [NUM_MOD-1:0][1:0]       chan_sel_r;
  logic      [NUM_MOD-1:0]            armed_r;
  arc_seq_e                           seq_r    [NUM_MOD];
  arc_seq_e                           seq_nxt  [NUM_MOD];
  logic      [NUM_MOD-1:0][1:0]       cur_r;
  logic      [NUM_MOD-1:0][1:0]       cur_nxt;
  logic      [NUM_MOD-1:0]            req_r;
  logic      [NUM_MOD-1:0][2:0]       chan_out_r;
  logic      [NUM_MOD-1:0]            irq_r;
  logic      [NUM_MOD-1:0]            conv_done;
  logic      [NUM_MOD-1:0][RES_W-1:0] conv_data;
  arc_csr_s  [NUM_MOD-1:0]            csr_view;

  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
    logic csr_wr;
    logic csr_rd;
    logic start_wr;
    logic done;
    logic last;
    logic fin;
    logic flag_clr;
    logic xfer_clr;

    assign csr_wr   = BUS_WR && BUS_AD == OFS_CSR[m];
    assign csr_rd   = BUS_RD && BUS_AD == OFS_CSR[m];
    assign start_wr = BUS_WR && BUS_AD == OFS_START[m];
    assign done     = CONV_RET[m].done && seq_r[m] == SEQ_RUN;
    // in single mode every finished conversion is the last one
    assign last     = (mode_r[m] == MODE_SINGLE) ||
                      (cur_r[m] == chan_sel_r[m]);
    assign fin      = done && last;
    // result reads of this module only; the other module's flag is untouched
    assign xfer_clr = res_rd && BUS_XFER && !XFER_MODE_BIT &&
                      BUS_AD[3] == 1'(m);
    assign flag_clr = (csr_wr && armed_r[m] &&
                       !BUS_WDATA[CSR_END_FLAG_BIT]) ||
                      xfer_clr;

    // next sequencer state; software stop and standby beat a completion
    always_comb begin
      seq_nxt[m] = seq_r[m];
      cur_nxt[m] = cur_r[m];
      if (STANDBY) begin
        seq_nxt[m] = SEQ_IDLE;
      end else if (start_wr) begin
        if (!BUS_WDATA[START_BIT]) begin
          seq_nxt[m] = SEQ_IDLE;
        end else if (seq_r[m] == SEQ_IDLE) begin
          seq_nxt[m] = SEQ_RUN;
          cur_nxt[m] = (mode_r[m] == MODE_SCAN) ? 2'h0
                                                : chan_sel_r[m];
        end
      end else if (done) begin
        if (mode_r[m] == MODE_SINGLE) begin
          seq_nxt[m] = SEQ_IDLE;
        end else if (last) begin
          cur_nxt[m] = 2'h0;
        end else begin
          cur_nxt[m] = 2'(cur_r[m] + 2'h1);
        end
      end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        seq_r[m]      <= SEQ_IDLE;
        cur_r[m]      <= 2'h0;
        req_r[m]      <= 1'b0;
        chan_out_r[m] <= 3'h0;
      end else begin
        seq_r[m]      <= seq_nxt[m];
        cur_r[m]      <= cur_nxt[m];
        req_r[m]      <= (seq_nxt[m] == SEQ_RUN);
        chan_out_r[m] <= {1'(m), cur_nxt[m]};
      end
    end

    // control fields; changing them mid-run is left to software
    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        irq_en_r[m]   <= 1'b0;
        mode_r[m]     <= MODE_SINGLE;
        chan_sel_r[m] <= 2'h0;
      end else if (csr_wr) begin
        irq_en_r[m]   <= BUS_WDATA[CSR_IRQ_EN_BIT];
        mode_r[m]     <= arc_mode_e'(BUS_WDATA[CSR_MODE_BIT]);
        chan_sel_r[m] <= BUS_WDATA[CSR_CHAN_LSB +: 2];
      end
    end

    // end flag: a completion in the clearing cycle wins
    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        end_flag_r[m] <= 1'b0;
      end else begin
        end_flag_r[m] <= fin || (end_flag_r[m] && !flag_clr);
      end
    end

    // a zero write only clears once the flag has been seen as one
    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        armed_r[m] <= 1'b0;
      end else if (csr_rd && end_flag_r[m]) begin
        armed_r[m] <= 1'b1;
      end else if (csr_wr || flag_clr) begin
        armed_r[m] <= 1'b0;
      end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
        irq_r[m] <= 1'b0;
      end else begin
        irq_r[m] <= end_flag_r[m] && irq_en_r[m];
      end
    end

    assign conv_done[m] = done;
    assign conv_data[m] = CONV_RET[m].data;

    always_comb begin
      csr_view[m].end_flag = end_flag_r[m];
      csr_view[m].irq_en   = irq_en_r[m];
      csr_view[m].rsv5     = RSV5_VALUE;
      csr_view[m].mode     = mode_r[m];
      csr_view[m].rsv3     = RSV3_VALUE;
      csr_view[m].rsv2     = RSV2_VALUE;
      csr_view[m].chan     = chan_sel_r[m];
    end
  end

  // ----------------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------------
  logic [7:0] res_hi;
  logic [7:0] res_lo;

  arc_result_bank u_bank (
    .clk      (MCLK),
    .rst_n    (NRST),
    .wr_en    (conv_done),
    .wr_sel   (cur_r),
    .wr_data  (conv_data),
    .rd_hi    (res_rd_hi),
    .rd_idx   (res_idx),
    .hi_byte  (res_hi),
    .lo_latch (res_lo)
  );

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // lower byte reads the latch: master must read upper first
  always_comb begin
    rdata_nxt = 8'h00;
    if (res_rd) begin
      rdata_nxt = BUS_AD[0] ? res_lo : res_hi;
    end else begin
      for (int m = 0; m < NUM_MOD; m++) begin
        if (BUS_AD == OFS_CSR[m]) begin
          rdata_nxt = csr_view[m];
        end
        if (BUS_AD == OFS_START[m]) begin
          rdata_nxt = 8'(req_r[m]) << START_BIT;
        end
      end
    end
  end

  // unmapped addresses answer zero; data holds until the next read
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= RDATA_RESET;
    end else if (BUS_RD) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign BUS_RDATA    = rdata_r;
  assign CONV_REQ     = req_r;
  assign CONV_CHAN    = chan_out_r;
  assign CONV_END_IRQ = irq_r;

endmodule

// File: hdl/arc_pkg.sv
//------------------------------------------------------------------------------
// Purpose : shared constants and types of the converter result/control regs
// Assumes : 8-bit CPU bus, two modules of four analog inputs each
// Notes   : all offsets are byte addresses on the 5-bit register address
//------------------------------------------------------------------------------
package arc_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CH     = 8;
  localparam int NUM_MOD    = 2;
  localparam int CH_PER_MOD = 4;
  localparam int RES_W      = 10;
  localparam int RES_LSB    = 6;   // value sits in bits 15:6 of a result

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  // result n: upper byte at 2n, lower byte at 2n+1
  localparam logic [4:0] OFS_RESULT_BASE = 5'h00;
  localparam logic [4:0] OFS_CSR_M0      = 5'h10;
  localparam logic [4:0] OFS_CSR_M1      = 5'h11;
  localparam logic [4:0] OFS_START_M0    = 5'h12;
  localparam logic [4:0] OFS_START_M1    = 5'h13;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CSR_END_FLAG_BIT = 7;
  localparam int CSR_IRQ_EN_BIT   = 6;
  localparam int CSR_MODE_BIT     = 4;
  localparam int CSR_CHAN_LSB     = 0;
  localparam int START_BIT        = 4;

  // ----------------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
  localparam logic             RSV5_VALUE   = 1'b0;
  localparam logic             RSV3_VALUE   = 1'b1;
  localparam logic             RSV2_VALUE   = 1'b0;
  localparam logic [7:0]       RDATA_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic {MODE_SINGLE, MODE_SCAN} arc_mode_e;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} arc_seq_e;

  // one conversion handed back by the analog sequencer
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] data;
  } arc_conv_s;

  // readback layout of a control/status register
  typedef struct packed {
    logic       end_flag;
    logic       irq_en;
    logic       rsv5;
    logic       mode;
    logic       rsv3;
    logic       rsv2;
    logic [1:0] chan;
  } arc_csr_s;

endpackage

// File: hdl/arc_result_bank.sv
//------------------------------------------------------------------------------
// Purpose : eight conversion results plus the lower-byte temporary latch
// Assumes : at most one write per module per cycle
// Notes   : upper byte is combinational, lower byte comes from the latch
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module arc_result_bank
  import arc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [NUM_MOD-1:0]          wr_en,
  input  wire logic [NUM_MOD-1:0][1:0]     wr_sel,
  input  wire logic [NUM_MOD-1:0][RES_W-1:0] wr_data,
  input  wire logic                        rd_hi,
  input  wire logic [2:0]                  rd_idx,
  output logic      [7:0]                  hi_byte,
  output logic      [7:0]                  lo_latch
);

  logic [RES_W-1:0] result_r [NUM_CH];
  logic [7:0]       lo_latch_r;

  // ----------------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------------
  for (genvar n = 0; n < NUM_CH; n++) begin : g_res
    localparam int M = n / CH_PER_MOD;
    localparam logic [1:0] SEL = 2'(n % CH_PER_MOD);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        result_r[n] <= RESULT_RESET;
      end else if (wr_en[M] && wr_sel[M] == SEL) begin
        result_r[n] <= wr_data[M];
      end
    end
  end

  // ----------------------------------------------------------------------
  // temporary latch
  // ----------------------------------------------------------------------
  // a result landing in the same cycle still pairs old upper with old lower
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_latch_r <= 8'h00;
    end else if (rd_hi) begin
      lo_latch_r <= {result_r[rd_idx][1:0], 6'h00};
    end
  end

  assign hi_byte  = result_r[rd_idx][RES_W-1:2];
  assign lo_latch = lo_latch_r;

endmodule

// File: tb/arc_conv_regs_sva.sv
//----------------------------------------------------------------------
// Purpose : port-level checks of the converter register block
// Assumes : one clock domain, NRST asynchronous and active low
// Notes   : sees only the top module ports
//----------------------------------------------------------------------
`timescale 1ns/1ps
module arc_conv_regs_chk
  import arc_pkg::*;
(
  input wire logic                    MCLK,
  input wire logic                    NRST,
  input wire logic [4:0]              BUS_AD,
  input wire logic                    BUS_RD,
  input wire logic                    BUS_WR,
  input wire logic [7:0]              BUS_WDATA,
  input wire logic                    BUS_XFER,
  input wire logic                    XFER_MODE_BIT,
  input wire logic                    STANDBY,
  input wire arc_conv_s [NUM_MOD-1:0] CONV_RET,
  input wire logic [7:0]              BUS_RDATA,
  input wire logic [NUM_MOD-1:0]      CONV_REQ,
  input wire logic [NUM_MOD-1:0][2:0] CONV_CHAN,
  input wire logic [NUM_MOD-1:0]      CONV_END_IRQ
);
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  rdata_hold_a: assert property (
    !BUS_RD |=> $stable(BUS_RDATA))
    else $error("read data changed without a read");
  low_zero_a: assert property (
    BUS_RD && !BUS_AD[4] && BUS_AD[0] |=> BUS_RDATA[5:0] == 6'h00)
    else $error("result low six bits not zero");
  csr_fixed_a: assert property (
    BUS_RD && BUS_AD[4:1] == 4'h8 |=> {BUS_RDATA[5], BUS_RDATA[3:2]} == 3'b010)
    else $error("reserved status bits wrong");
  irq_follow_a: assert property (
    BUS_RD && BUS_AD == OFS_CSR_M0 |=>
      CONV_END_IRQ[0] == (BUS_RDATA[7] & BUS_RDATA[6]))
    else $error("interrupt differs from flag and enable");
  start_req_a: assert property (
    BUS_WR && BUS_AD == OFS_START_M0 && BUS_WDATA[START_BIT] && !STANDBY
      |=> CONV_REQ[0])
    else $error("start write did not start module 0");
  idle_hold_a: assert property (
    !CONV_REQ[1] && !(BUS_WR && BUS_AD == OFS_START_M1) |=> !CONV_REQ[1])
    else $error("module 1 started without a start write");
  standby_stop_a: assert property (
    STANDBY |=> CONV_REQ == 2'b00)
    else $error("standby did not stop conversion");
  chan_range_a: assert property (
    (!CONV_REQ[0] || !CONV_CHAN[0][2]) && (!CONV_REQ[1] || CONV_CHAN[1][2]))
    else $error("channel outside its module");
  chan_step_a: assert property (
    CONV_REQ[0] && CONV_RET[0].done |=> !CONV_REQ[0] || CONV_CHAN[0] == 3'h0
      || CONV_CHAN[0] == $past(CONV_CHAN[0]) + 3'h1)
    else $error("scan order not ascending");
endmodule

bind arc_conv_regs arc_conv_regs_chk chk (
  .MCLK(MCLK), .NRST(NRST), .BUS_AD(BUS_AD), .BUS_RD(BUS_RD),
  .BUS_WR(BUS_WR), .BUS_WDATA(BUS_WDATA), .BUS_XFER(BUS_XFER),
  .XFER_MODE_BIT(XFER_MODE_BIT), .STANDBY(STANDBY),
  .CONV_RET(CONV_RET), .BUS_RDATA(BUS_RDATA), .CONV_REQ(CONV_REQ),
  .CONV_CHAN(CONV_CHAN), .CONV_END_IRQ(CONV_END_IRQ));

// File: tb/arc_conv_regs_test.sv
//----------------------------------------------------------------------
// Purpose : directed register-level test of the converter block
// Assumes : one access per two cycles, upper byte read before lower
// Notes   : expected results rebuilt from the channel code
//----------------------------------------------------------------------
`timescale 1ns/1ps
module arc_conv_regs_test
  import arc_pkg::*;
;
  logic                    MCLK, NRST, BUS_RD, BUS_WR;
  logic                    BUS_XFER, XFER_MODE_BIT, STANDBY;
  logic [4:0]              BUS_AD;
  logic [7:0]              BUS_WDATA, BUS_RDATA, q;
  arc_conv_s [NUM_MOD-1:0] CONV_RET;
  logic [NUM_MOD-1:0]      CONV_REQ, CONV_END_IRQ;
  logic [NUM_MOD-1:0][2:0] CONV_CHAN;
  logic [3:0]              dly;
  int                      n_mismatch, samples_checked;
  int                      ndone [NUM_MOD];

  arc_conv_regs uut (.MCLK(MCLK), .NRST(NRST), .BUS_AD(BUS_AD),
    .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_WDATA(BUS_WDATA),
    .BUS_XFER(BUS_XFER), .XFER_MODE_BIT(XFER_MODE_BIT),
    .STANDBY(STANDBY), .CONV_RET(CONV_RET), .BUS_RDATA(BUS_RDATA),
    .CONV_REQ(CONV_REQ), .CONV_CHAN(CONV_CHAN),
    .CONV_END_IRQ(CONV_END_IRQ));
  arc_seq_model seq (.clk(MCLK), .rst_n(NRST), .dly(dly),
    .req(CONV_REQ), .chan(CONV_CHAN), .ret(CONV_RET));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  always @(posedge MCLK)
    for (int m = 0; m < NUM_MOD; m++)
      if (CONV_REQ[m] && CONV_RET[m].done) ndone[m] <= ndone[m] + 1;

  function automatic logic [7:0] res_b(input int ch, input bit lo);
    logic [9:0] v;
    v = {ch[2:0], 7'h55 ^ ch[6:0]};
    res_b = lo ? {v[1:0], 6'h00} : v[9:2];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge MCLK);
    #1;
    BUS_AD = a;
    BUS_WDATA = d;
    BUS_RD = !w;
    BUS_WR = w;
    @(posedge MCLK);
    #1;
    q = BUS_RDATA;
    BUS_RD = 1'b0;
    BUS_WR = 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  // bounded wait for module m: done (request low) or interrupt high
  task automatic await(input bit irq, input int m);
    int i;
    for (i = 0; i < 200; i++) begin
      if ((irq ? CONV_END_IRQ[m] : !CONV_REQ[m]) === 1'b1) break;
      @(posedge MCLK);
      #1;
    end
    chk({7'h00, i < 200}, 8'h01);
  endtask

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {NRST, BUS_RD, BUS_WR, BUS_XFER, XFER_MODE_BIT, STANDBY} = 6'h00;
    BUS_AD = 5'h00;
    BUS_WDATA = 8'h00;
    dly = 4'h6;
    n_mismatch = 0;
    samples_checked = 0;
    ndone = '{0, 0};
    repeat (4) @(posedge MCLK);
    #1;
    NRST = 1'b1;
    for (int a = 0; a < 32; a++)
      rc(a[4:0], (a == 16 || a == 17) ? 8'h08 : 8'h00);
    // slow partner, single mode on module 1, interrupt masked
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CSR_M1, 8'h08 | c[7:0]);
      wr(OFS_START_M1, 8'h10);
      await(1'b0, 1);
      wr(OFS_CSR_M1, 8'h88 | c[7:0]);
      wr(OFS_CSR_M1, 8'h08 | c[7:0]);
      chk({7'h00, CONV_END_IRQ[1]}, 8'h00);
      rc(OFS_CSR_M1, 8'h88 | c[7:0]);
      rc(OFS_START_M1, 8'h00);
      wr(OFS_CSR_M1, 8'h08 | c[7:0]);
      rc(OFS_CSR_M1, 8'h08 | c[7:0]);
      rc(5'(8 + 2 * c), res_b(4 + c, 0));
      rc(5'(9 + 2 * c), res_b(4 + c, 1));
    end
    // prompt partner, scan mode on module 0, every channel code
    dly = 4'h1;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CSR_M0, 8'h58 | c[7:0]);
      ndone[0] = 0;
      wr(OFS_START_M0, 8'h10);
      await(1'b1, 0);
      chk(ndone[0][7:0], 8'(c + 1));
      wr(OFS_START_M0, 8'h00);
      rc(OFS_CSR_M0, 8'hd8 | c[7:0]);
      wr(OFS_CSR_M0, 8'h58 | c[7:0]);
      rc(OFS_CSR_M0, 8'h58 | c[7:0]);
      chk({7'h00, CONV_END_IRQ[0]}, 8'h00);
      for (int k = 0; k <= c; k++)
        rc(5'(2 * k), res_b(k, 0));
    end
    // transfer-controller reads clear the flag only with mode bit zero
    wr(OFS_CSR_M0, 8'h49);
    wr(OFS_START_M0, 8'h10);
    await(1'b0, 0);
    BUS_XFER = 1'b1;
    XFER_MODE_BIT = 1'b1;
    rc(5'h02, res_b(1, 0));
    rc(OFS_CSR_M0, 8'hc9);
    XFER_MODE_BIT = 1'b0;
    rc(5'h02, res_b(1, 0));
    BUS_XFER = 1'b0;
    rc(OFS_CSR_M0, 8'h49);
    rc(5'h0a, res_b(5, 0));
    rc(5'h03, res_b(5, 1));
    wr(5'h0a, 8'hff);
    rc(5'h0a, res_b(5, 0));
    wr(5'h1f, 8'hff);
    rc(5'h1f, 8'h00);
    wr(OFS_CSR_M0, 8'h5b);
    wr(OFS_START_M0, 8'h10);
    STANDBY = 1'b1;
    rc(OFS_START_M0, 8'h00);
    STANDBY = 1'b0;
    NRST = 1'b0;
    @(posedge MCLK);
    #1;
    NRST = 1'b1;
    rc(5'h08, 8'h00);
    rc(OFS_CSR_M0, 8'h08);
    finish_test();
  end
endmodule

// File: tb/arc_seq_model.sv
//----------------------------------------------------------------------
// Purpose : analog sequencer stand-in, one done pulse per conversion
// Assumes : dly of at least 1, changed only between runs
// Notes   : data is a fixed code of the channel so results are checkable
//----------------------------------------------------------------------
`timescale 1ns/1ps
module arc_seq_model
  import arc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              dly,
  input  wire logic [NUM_MOD-1:0]      req,
  input  wire logic [NUM_MOD-1:0][2:0] chan,
  output arc_conv_s [NUM_MOD-1:0]      ret
);
  logic [NUM_MOD-1:0][3:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      ret   <= '0;
    end else begin
      for (int m = 0; m < NUM_MOD; m++) begin
        ret[m].done <= 1'b0;
        // data outside a done pulse toggles, so it equals the last result every other cycle
        ret[m].data <= ~ret[m].data;
        if (!req[m]) begin
          cnt_r[m] <= 4'h0;
        end else if (cnt_r[m] == dly) begin
          cnt_r[m]    <= 4'h0;
          ret[m].done <= 1'b1;
          ret[m].data <= {chan[m], 7'h55 ^ {4'h0, chan[m]}};
        end else begin
          cnt_r[m] <= cnt_r[m] + 4'h1;
        end
      end
    end
  end
endmodule
